// File: rtl/state_capture_trigger.sv
// State-mode capture, trigger and trace memory of a logic analyzer
//
// Behaviour
// RL1: Sample only on the target's external clock.
// RL2: Clock one enters via pod one; operator selects.
// RL3: Each clock off, rising or falling edge.
// RL4: Eight pattern qualifiers a to h.
// RL5: Trigger on Nth match of selected qualifier.
// RL6: Store continuously, after trigger until memory full.
// RL7: Run command arms; then watch every state.
// RL8: Trigger state has index zero.
// RL9: Earlier states negative, later states positive.
// RL10: Sixteen channels per pod, bits assigned to labels.
// RL11: Labels may span pods or partial pods.
// RL12: Don't-care digits excluded from comparison.
// RL13: Trigger kept mid-memory, equal pre and post; code keeps up to 128 states before, 127 after.
`timescale 1ns/1ns
`default_nettype none
module state_capture_trigger
  import sc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic [SMP_W-1:0] i_pod_data,
  input wire logic [NUM_CLK-1:0] i_pod_clk,
  input wire logic [NUM_CLK-1:0][1:0] i_clk_mode,
  input wire logic [NUM_LABELS-1:0][SMP_W-1:0] i_label_bits,
  input wire logic [NUM_QUAL-1:0][NUM_LABELS-1:0][SMP_W-1:0] i_qual_value,
  input wire logic [NUM_QUAL-1:0][NUM_LABELS-1:0][SMP_W-1:0] i_qual_care,
  input wire logic [2:0] i_trig_sel,
  input wire logic [CNT_W-1:0] i_trig_count,
  input wire logic i_run,
  input wire logic signed [IDX_W-1:0] i_rd_index,
  input wire logic i_rd_req,
  output logic o_armed,
  output logic o_triggered,
  output logic o_done,
  output logic [IDX_W-1:0] o_pre_count,
  output logic [IDX_W-1:0] o_post_count,
  output logic [SMP_W-1:0] o_rd_data,
  output logic o_rd_valid
);
  // Every flop of the core except the trace memory and its read register lives in this one record
  typedef struct packed {
    // Two-stage synchronisers for pod data and pod clocks
    logic [SMP_W-1:0] pod_s1;
    logic [SMP_W-1:0] pod_s2;
    logic [NUM_CLK-1:0] clk_s1;
    logic [NUM_CLK-1:0] clk_s2;
    // Previous synchronised clock level, for edge finding
    logic [NUM_CLK-1:0] clk_d;
    // Sampled state and its one-cycle valid strobe
    logic [SMP_W-1:0] smp;
    logic smp_v;
    // Acquisition bookkeeping
    acq_state_t st;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] trig_ptr;
    logic [CNT_W-1:0] occ;
    logic [IDX_W-1:0] n_pre;
    logic [IDX_W-1:0] n_post;
    // Read answer strobe
    logic rd_valid;
    // Status flags, kept as flops so the outputs need no decode
    logic armed;
    logic trig_seen;
    logic full;
  } core_t;

  core_t r;
  core_t next_r;
  // Carrier to the qualifier comparators
  match_if m();
  // Trace memory: a ring of DEPTH sampled states, plus its read register
  logic [SMP_W-1:0] mem [DEPTH];
  logic [SMP_W-1:0] rd_data;
  // Combinational helpers of the next-state logic
  logic [NUM_CLK-1:0] edge_hit;
  logic store;
  logic fire;
  logic [CNT_W-1:0] occ_inc;
  logic [CNT_W-1:0] need;
  logic [IDX_W-1:0] back;
  logic rd_ok;
  logic [AW-1:0] rd_addr;

  // The comparators see the latest sample; smp_v says whether it is new
  assign m.state = r.smp;

  qualifier_match u_match (
    .m(m),
    .i_label_bits(i_label_bits),
    .i_qual_value(i_qual_value),
    .i_qual_care(i_qual_care)
  );

  // Edge finder per pod clock; only the second synchroniser stage is looked at
  // A pod clock faster than half the core clock will lose edges
  for (genvar c = 0; c < NUM_CLK; c++) begin : g_clk
    assign edge_hit[c] = (i_clk_mode[c] == CLK_RISE) ? (r.clk_s2[c] & ~r.clk_d[c]) :
                         (i_clk_mode[c] == CLK_FALL) ? (~r.clk_s2[c] & r.clk_d[c]) :
                         1'b0; // RL2 RL3
  end

  // Trigger arithmetic; a zero occurrence count behaves as one
  // The match counter stops at the requested count, so it cannot wrap
  assign need = (i_trig_count == OCC_RST) ? 16'h0001 : i_trig_count; // RL5
  assign occ_inc = r.occ + 16'h0001;
  assign store = r.smp_v && (r.st == S_PRE || r.st == S_POST); // RL6
  assign fire = r.smp_v && r.st == S_PRE && m.hit[i_trig_sel] && occ_inc >= need; // RL5 RL7

  // Readout range check: earlier states count backwards from the trigger
  // Limitation: reads are answered only after acquisition has stopped
  assign back = IDX_W'(-i_rd_index);
  assign rd_ok = r.st == S_DONE && (i_rd_index[IDX_W-1] ?
                 (back <= r.n_pre && back <= PRE_MAX) :
                 (IDX_W'(i_rd_index) <= r.n_post)); // RL8 RL9
  assign rd_addr = r.trig_ptr + AW'(i_rd_index); // RL8 RL9

  // Next-state logic of the whole capture core
  always_comb begin
    next_r = r;
    next_r.pod_s1 = i_pod_data;
    next_r.pod_s2 = r.pod_s1;
    next_r.clk_s1 = i_pod_clk;
    next_r.clk_s2 = r.clk_s1;
    next_r.clk_d = r.clk_s2;

    // Data and clock share the same two-stage delay, so the edge lines up
    next_r.smp_v = |edge_hit; // RL1
    if (|edge_hit) begin
      next_r.smp = r.pod_s2; // RL1
    end

    // A read is answered only inside the stored window
    next_r.rd_valid = i_rd_req && rd_ok;

    // Every stored state advances the ring pointer
    if (store) begin
      next_r.wr_ptr = r.wr_ptr + 8'h01; // RL6
    end

    // Acquisition sequencing
    case (r.st)
      S_IDLE: begin
        next_r.smp_v = 1'b0; // Nothing is taken until armed
      end
      S_PRE: begin
        // Count matches; the Nth one becomes index zero
        if (r.smp_v && m.hit[i_trig_sel]) begin
          next_r.occ = occ_inc; // RL5
        end
        if (fire) begin
          next_r.st = S_POST;
          next_r.trig_ptr = r.wr_ptr; // RL8
          next_r.n_post = IDX_RST;
        end else if (store && r.n_pre != PRE_MAX) begin
          // Pre count saturates; older states are then overwritten in the ring
          next_r.n_pre = r.n_pre + 9'h001; // RL13
        end
      end
      S_POST: begin
        // Stop once the post half of the ring is filled
        if (store) begin
          next_r.n_post = r.n_post + 9'h001; // RL9
          if (r.n_post + 9'h001 == POST_LEN) begin
            next_r.st = S_DONE; // RL6 RL13
          end
        end
      end
      S_DONE: begin
        next_r.smp_v = 1'b0;
      end
      default: begin
        next_r.st = S_IDLE;
      end
    endcase

    // A run command restarts acquisition from any state
    // It is applied last, so it wins over a trigger in the same cycle
    if (i_run) begin
      next_r.st = S_PRE; // RL7
      next_r.occ = OCC_RST;
      next_r.n_pre = IDX_RST;
      next_r.n_post = IDX_RST;
      next_r.wr_ptr = PTR_RST;
      next_r.trig_ptr = PTR_RST;
      next_r.smp_v = 1'b0;
    end

    // Flags follow the next state, so they move in the same cycle as it
    next_r.armed = next_r.st == S_PRE; // RL7
    next_r.trig_seen = next_r.st == S_POST || next_r.st == S_DONE; // RL5
    next_r.full = next_r.st == S_DONE; // RL6
  end

  // State register; a synchronous reset clears every field, which is idle
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      r <= '0;
      r.st <= S_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // Trace memory; kept out of reset so it maps onto block RAM
  always_ff @(posedge i_core_clk) begin
    // The write takes the registered sample, so address and data agree
    if (store) begin
      mem[r.wr_ptr] <= r.smp; // RL6
    end
    // Read port is registered; its address follows the index every cycle
    rd_data <= mem[rd_addr];
  end

  // Status outputs, each a flop of the core record
  assign o_armed = r.armed;
  assign o_triggered = r.trig_seen;
  assign o_done = r.full;

  // Counters and readout, also straight from flops
  assign o_pre_count = r.n_pre;
  assign o_post_count = r.n_post;
  assign o_rd_data = rd_data;
  assign o_rd_valid = r.rd_valid;
endmodule : state_capture_trigger
`default_nettype wire

// File: shared/sc_pkg.sv
// Shared constants and types of the state capture and trigger block
package sc_pkg;
  localparam int POD_W = 16;
  localparam int NUM_PODS = 3;
  localparam int SMP_W = POD_W * NUM_PODS;
  localparam int NUM_CLK = NUM_PODS;
  localparam int NUM_QUAL = 8;
  localparam int NUM_LABELS = 2;
  localparam int AW = 8;
  localparam int DEPTH = 1 << AW;
  localparam int IDX_W = AW + 1;
  localparam int CNT_W = 16;
  // Trigger sits mid-memory: this many states kept before and after it
  localparam logic [IDX_W-1:0] PRE_MAX = 9'h080;
  localparam logic [IDX_W-1:0] POST_LEN = 9'h07f;
  // Per-clock edge selection codes
  localparam logic [1:0] CLK_OFF = 2'h0;
  localparam logic [1:0] CLK_RISE = 2'h1;
  localparam logic [1:0] CLK_FALL = 2'h2;
  // Reset values
  localparam logic [AW-1:0] PTR_RST = 8'h00;
  localparam logic [IDX_W-1:0] IDX_RST = 9'h000;
  localparam logic [CNT_W-1:0] OCC_RST = 16'h0000;
  typedef enum logic [1:0] {S_IDLE, S_PRE, S_POST, S_DONE} acq_state_t;
endpackage : sc_pkg

// File: shared/match_if.sv
// Carrier between the capture core and the qualifier comparator
`timescale 1ns/1ns
`default_nettype none
interface match_if;
  import sc_pkg::*;
  logic [SMP_W-1:0] state;
  logic [NUM_QUAL-1:0] hit;
  modport core (output state, input hit);
  modport cmp (input state, output hit);
endinterface : match_if
`default_nettype wire

// File: rtl/qualifier_match.sv
// Eight pattern qualifiers compared against the sampled state
`timescale 1ns/1ns
`default_nettype none
module qualifier_match
  import sc_pkg::*;
(
  match_if.cmp m,
  input wire logic [NUM_LABELS-1:0][SMP_W-1:0] i_label_bits,
  input wire logic [NUM_QUAL-1:0][NUM_LABELS-1:0][SMP_W-1:0] i_qual_value,
  input wire logic [NUM_QUAL-1:0][NUM_LABELS-1:0][SMP_W-1:0] i_qual_care
);
  // One comparator per qualifier a..h; a label may gather bits of any pods
  for (genvar q = 0; q < NUM_QUAL; q++) begin : g_qual
    logic [NUM_LABELS-1:0] lab_ok;
    for (genvar l = 0; l < NUM_LABELS; l++) begin : g_lab
      // Only assigned bits with specified digits take part in the compare
      assign lab_ok[l] = ~|((m.state ^ i_qual_value[q][l])
                            & i_qual_care[q][l] & i_label_bits[l]); // RL4 RL10 RL11 RL12
    end
    assign m.hit[q] = &lab_ok; // RL4
  end
endmodule : qualifier_match
`default_nettype wire

// File: tb/sct_props.sv
// Port checker of the capture and trigger block
`timescale 1ns/1ns
`default_nettype none
module sct_props
  import sc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_run,
  input wire logic signed [IDX_W-1:0] i_rd_index,
  input wire logic i_rd_req,
  input wire logic o_armed,
  input wire logic o_triggered,
  input wire logic o_done,
  input wire logic [IDX_W-1:0] o_pre_count,
  input wire logic [IDX_W-1:0] o_post_count,
  input wire logic o_rd_valid
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  // Readable window; int keeps a negative index signed when compared with the unsigned counts
  logic in_win;
  assign in_win = int'(i_rd_index) <= int'(o_post_count) && -int'(i_rd_index) <= int'(o_pre_count);
  sequence s_clr;
    o_armed && !o_triggered && !o_done && o_pre_count == IDX_RST;
  endsequence
  sequence s_req;
    i_rd_req && o_done && in_win;
  endsequence
  property p_rst_idle; $fell(i_srst) |-> !o_armed && !o_triggered && !o_done; endproperty
  property p_run_arms; i_run |=> s_clr; endproperty
  property p_fire; $rose(o_triggered) |-> $past(o_armed) && !o_armed; endproperty
  property p_done; o_done |-> o_triggered && o_post_count == POST_LEN; endproperty
  property p_pre_cap; o_pre_count <= PRE_MAX; endproperty
  property p_post_trig; o_post_count != IDX_RST |-> o_triggered; endproperty
  property p_done_hold; o_done && !i_run |=> o_done; endproperty
  property p_rd_ok; s_req |=> o_rd_valid; endproperty
  property p_rd_no; !(i_rd_req && o_done && in_win) |=> !o_rd_valid; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("busy after reset");
  a_run_arms: assert property (p_run_arms) else $error("run did not arm");
  a_fire: assert property (p_fire) else $error("trigger while not armed");
  a_done: assert property (p_done) else $error("stopped short");
  a_pre_cap: assert property (p_pre_cap) else $error("pre count too big");
  a_post_trig: assert property (p_post_trig) else $error("post before trigger");
  a_done_hold: assert property (p_done_hold) else $error("done dropped");
  a_rd_ok: assert property (p_rd_ok) else $error("read not answered");
  a_rd_no: assert property (p_rd_no) else $error("bad read answered");
endmodule : sct_props
bind state_capture_trigger sct_props sct_props_i (.i_core_clk(i_core_clk), .i_srst(i_srst),
  .i_run(i_run), .i_rd_index(i_rd_index), .i_rd_req(i_rd_req), .o_armed(o_armed),
  .o_triggered(o_triggered), .o_done(o_done), .o_pre_count(o_pre_count),
  .o_post_count(o_post_count), .o_rd_valid(o_rd_valid));
`default_nettype wire

// File: tb/target_model.sv
// Target stand-in: pod clocks and a counting word on all pods
`timescale 1ns/1ns
`default_nettype none
module target_model
  import sc_pkg::*;
(
  input wire logic i_en,
  output logic [NUM_CLK-1:0] o_clk,
  output logic [SMP_W-1:0] o_data
);
  logic [15:0] n;
  // One process drives the pins; clock runs only in a frame
  // Data moves between edges so both edges see it settled
  initial begin
    o_clk = '0;
    o_data = '0;
    n = 16'h0000;
    forever begin
      @(posedge i_en);
      n = 16'h0000;
      o_data = {3{n}};
      while (i_en) begin
        #40 o_clk = '1;
        #40 n = n + 16'h0001;
        o_data = {3{n}};
        #40 o_clk = '0;
        #40;
      end
    end
  end
endmodule : target_model
`default_nettype wire

// File: tb/state_capture_trigger_tb_top.sv
// Self-checking bench of the capture and trigger block
`timescale 1ns/1ns
`default_nettype none
module state_capture_trigger_tb_top
  import sc_pkg::*;
;
  // Row: clock modes, qualifier, count, pattern, expected trigger word, expected pre count
  typedef struct {logic [5:0] m; int q; int c; int v; int k; int p;} row_t;
  row_t rows[4] = '{'{6'h01, 0, 1, 3, 3, 3}, '{6'h02, 7, 2, 5, 21, 20},
                    '{6'h05, 2, 9, 1, 129, 128}, '{6'h01, 4, 0, 6, 6, 6}};
  logic clk = 0, srst = 1, run = 0, req = 0, en = 0, armed, trig, done, rv;
  logic [NUM_CLK-1:0] pclk;
  logic [SMP_W-1:0] pdat, rdat;
  logic [NUM_CLK-1:0][1:0] mode = '0;
  logic [NUM_LABELS-1:0][SMP_W-1:0] lbits = '0;
  logic [NUM_QUAL-1:0][NUM_LABELS-1:0][SMP_W-1:0] qv = '0, qc = '0;
  logic [2:0] sel = '0;
  logic [CNT_W-1:0] cnt = '0;
  logic signed [IDX_W-1:0] idx = '0;
  logic [IDX_W-1:0] pre, post;
  int n_errors = 0, checked = 0;
  target_model target_model_i (.i_en(en), .o_clk(pclk), .o_data(pdat));
  state_capture_trigger state_capture_trigger_i (.i_core_clk(clk), .i_srst(srst),
    .i_pod_data(pdat), .i_pod_clk(pclk), .i_clk_mode(mode), .i_label_bits(lbits),
    .i_qual_value(qv), .i_qual_care(qc), .i_trig_sel(sel), .i_trig_count(cnt), .i_run(run),
    .i_rd_index(idx), .i_rd_req(req), .o_armed(armed), .o_triggered(trig), .o_done(done),
    .o_pre_count(pre), .o_post_count(post), .o_rd_data(rdat), .o_rd_valid(rv));
  initial forever #10 clk = ~clk;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input bit ok, input string what);
    checked++;
    if (!ok) begin
      n_errors++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask : chk
  task automatic rd(input int i, input logic [SMP_W-1:0] e, input bit ok);
    @(negedge clk) idx = 9'(i);
    req = 1;
    @(negedge clk) req = 0;
    chk(rv === ok && (!ok || rdat === e), "read answer");
  endtask : rd
  // Only the low nibble of pod one is compared, so each row knows its trigger word
  task automatic run_case(input row_t r);
    @(negedge clk) mode = r.m;
    sel = 3'(r.q);
    cnt = 16'(r.c);
    for (int q = 0; q < NUM_QUAL; q++) qv[q][0] = 48'(q == r.q ? r.v : r.v ^ 1);
    run = 1;
    en = 1;
    @(negedge clk) run = 0;
    for (int i = 0; i < 4000 && done !== 1'b1; i++) @(negedge clk);
    en = 0;
    chk(done === 1'b1 && pre === 9'(r.p) && post === POST_LEN, "fill counts");
    rd(0, {3{16'(r.k)}}, 1);
    rd(-1, {3{16'(r.k - 1)}}, 1);
    rd(127, {3{16'(r.k + 127)}}, 1);
    rd(-r.p - 1, '0, 0);
  endtask : run_case
  initial begin
    lbits[0] = 48'h0000_0000_000f;
    for (int q = 0; q < NUM_QUAL; q++) qc[q][0] = 48'h0000_0000_000f;
    repeat (10) @(negedge clk);
    srst = 0;
    chk(armed === 1'b0 && trig === 1'b0 && done === 1'b0, "busy after reset");
    foreach (rows[r]) begin
      run_case(rows[r]);
      $display("case %0d done", r);
    end
    // All clocks off: armed but nothing sampled
    @(negedge clk) mode = '0;
    run = 1;
    en = 1;
    @(negedge clk) run = 0;
    repeat (200) @(negedge clk);
    chk(armed === 1'b1 && trig === 1'b0, "sampled with clocks off");
    rd(0, '0, 0);
    srst = 1;
    @(negedge clk) srst = 0;
    en = 0;
    chk(armed === 1'b0 && done === 1'b0, "busy after mid-run reset");
    $display("hand tests done");
    tally_and_finish();
  end
  // Watchdog: about nine times the expected length of all tests
  initial begin
    #1_000_000;
    n_errors++;
    tally_and_finish();
  end
endmodule : state_capture_trigger_tb_top
`default_nettype wire
